//--- rx_alarm_pkg.sv
// Purpose: Shared constants and types for the received-power alarm latch bank
// Assumes: Avalon-MM byte addressing, one 32-bit word per register
// Notes:   Printed offsets are register indices; byte address is four times the index

package rx_alarm_pkg;

    // ---------------------------------------------------------------
    // Register indices and byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] LATCH_CH7_CH6_IDX = 8'h18;
    localparam logic [7:0] LATCH_CH5_CH4_IDX = 8'h19;
    localparam logic [7:0] TEMP_MSB_IDX = 8'h1C;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
    localparam logic [7:0] IRQ_CLEAR_IDX = 8'h21;
    localparam logic [7:0] IRQ_ENABLE_IDX = 8'h22;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] LATCH_CH7_CH6_ADDR = {LATCH_CH7_CH6_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] LATCH_CH5_CH4_ADDR = {LATCH_CH5_CH4_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] TEMP_MSB_ADDR = {TEMP_MSB_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = {IRQ_CLEAR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = {IRQ_ENABLE_IDX, 2'h0};

    // ---------------------------------------------------------------
    // Field positions inside an alarm byte
    // ---------------------------------------------------------------
    localparam int HI_UPPER_BIT = 7;
    localparam int LO_UPPER_BIT = 6;
    localparam int HI_LOWER_BIT = 3;
    localparam int LO_LOWER_BIT = 2;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int TEMP_UPDATE_US = 1;
    localparam int TEMP_UPDATE_CYCLES = TEMP_UPDATE_US * CLOCK_MHZ;
    localparam int TEMP_CNT_W = 8;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    // Index 0..3 stands for channels 4..7
    typedef struct packed {
        logic [3:0] low;
        logic [3:0] high;
    } rx_alarm_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

endpackage

//--- alarm_flag_bank.sv
// Purpose: Eight sticky alarm flags, cleared only for the bits a read returned
// Assumes: Conditions are synchronous levels from the power comparators
// Notes:   A condition present in the clearing cycle keeps the flag set

`timescale 1ns/1ps

module alarm_flag_bank
    import rx_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Conditions and clear
    input wire logic [7:0] cond,
    input wire logic [7:0] clearMask,
    // Flag state
    output logic [7:0] flags,
    output logic [7:0] newSet
);

    logic [7:0] flag_q;
    logic [7:0] flag_d;

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_flag
            always_comb
            begin
                flag_d[i] = cond[i] | (flag_q[i] & ~clearMask[i]);
                newSet[i] = cond[i] & ~flag_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            flag_q <= FLAGS_RESET;
        else
            flag_q <= flag_d;
    end

    assign flags = flag_q;

endmodule

//--- temp_snapshot.sv
// Purpose: Periodic snapshot of the internal temperature integer byte
// Assumes: Sensor delivers a signed two's-complement integer in degrees
// Notes:   Snapshot keeps the value stable across a bus read

`timescale 1ns/1ps

module temp_snapshot
    import rx_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Sensor
    input wire logic signed [7:0] tempInt,
    // Held value
    output logic signed [7:0] tempHeld
);

    localparam logic [TEMP_CNT_W-1:0] TICK_LAST = TEMP_CNT_W'(TEMP_UPDATE_CYCLES - 1);

    logic [TEMP_CNT_W-1:0] cnt_q;
    logic [TEMP_CNT_W-1:0] cnt_d;
    logic signed [7:0] temp_q;
    logic signed [7:0] temp_d;

    always_comb
    begin
        cnt_d = cnt_q + TEMP_CNT_W'(1);
        temp_d = temp_q;
        if (cnt_q == TICK_LAST)
        begin
            cnt_d = '0;
            temp_d = tempInt;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            temp_q <= TEMP_RESET;
        end
        else
        begin
            cnt_q <= cnt_d;
            temp_q <= temp_d;
        end
    end

    assign tempHeld = temp_q;

endmodule

//--- rx_power_alarm_latch_bank.sv
// Purpose: Latched received-power alarm flags for channels 7..4 behind Avalon-MM
// Assumes: One clock; comparator outputs and temperature synchronous to it
// Notes:   Every access sees one wait cycle
//
// Register access over Avalon-MM was chosen for this implementation.

`timescale 1ns/1ps

module rx_power_alarm_latch_bank
    import rx_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Comparators and sensor
    input wire rx_alarm_t rxAlarm,
    input wire logic signed [7:0] tempInt,
    // Interrupt
    output logic irq
);

    // ---------------------------------------------------------------
    // Request bundle
    // ---------------------------------------------------------------
    avmm_req_t req;

    always_comb
    begin
        req.address = address;
        req.read = read;
        req.write = write;
        req.writedata = writedata;
        req.byteenable = byteenable;
    end

    // ---------------------------------------------------------------
    // Flags and temperature
    // ---------------------------------------------------------------
    logic [7:0] flags;
    logic [7:0] newSet;
    logic [7:0] clearMask;
    logic signed [7:0] tempHeld;

    alarm_flag_bank u_flags (
        .clock(clock),
        .rst(rst),
        .cond(rxAlarm),
        .clearMask(clearMask),
        .flags(flags),
        .newSet(newSet)
    );

    temp_snapshot u_temp (
        .clock(clock),
        .rst(rst),
        .tempInt(tempInt),
        .tempHeld(tempHeld)
    );

    // ---------------------------------------------------------------
    // Byte images
    // ---------------------------------------------------------------
    rx_alarm_t fl;
    logic [7:0] byteCh7Ch6;
    logic [7:0] byteCh5Ch4;

    always_comb
    begin
        fl = rx_alarm_t'(flags);
        byteCh7Ch6 = 8'h00;
        byteCh5Ch4 = 8'h00;
        byteCh7Ch6[HI_UPPER_BIT] = fl.high[3];
        byteCh7Ch6[LO_UPPER_BIT] = fl.low[3];
        byteCh7Ch6[HI_LOWER_BIT] = fl.high[2];
        byteCh7Ch6[LO_LOWER_BIT] = fl.low[2];
        byteCh5Ch4[HI_UPPER_BIT] = fl.high[1];
        byteCh5Ch4[LO_UPPER_BIT] = fl.low[1];
        byteCh5Ch4[HI_LOWER_BIT] = fl.high[0];
        byteCh5Ch4[LO_LOWER_BIT] = fl.low[0];
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // Word-aligned addresses only; anything else hits nothing and
    // reads back as zero.
    logic hitLatch76;
    logic hitLatch54;
    logic hitTemp;
    logic hitStatus;
    logic hitClear;
    logic hitEnable;
    logic anyReq;

    always_comb
    begin
        hitLatch76 = (req.address == LATCH_CH7_CH6_ADDR);
        hitLatch54 = (req.address == LATCH_CH5_CH4_ADDR);
        hitTemp = (req.address == TEMP_MSB_ADDR);
        hitStatus = (req.address == IRQ_STATUS_ADDR);
        hitClear = (req.address == IRQ_CLEAR_ADDR);
        hitEnable = (req.address == IRQ_ENABLE_ADDR);
        anyReq = req.read | req.write;
    end

    // ---------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------
    // Exactly one wait state: answer captured on the first edge,
    // request taken on the second. Costs a cycle, keeps readdata
    // and waitrequest straight from flip-flops.
    typedef enum {IDLE, ANSWER} bus_state_t;

    bus_state_t busState_q;
    bus_state_t busState_d;
    logic wait_q;
    logic wait_d;
    logic capture;
    logic accept;

    always_comb
    begin
        capture = 1'b0;
        accept = 1'b0;
        busState_d = busState_q;
        case (busState_q)
            IDLE:
            begin
                if (anyReq)
                begin
                    capture = 1'b1;
                    busState_d = ANSWER;
                end
            end
            ANSWER:
            begin
                accept = anyReq;
                busState_d = IDLE;
            end
            default: busState_d = IDLE;
        endcase
        wait_d = (busState_d == IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            busState_q <= IDLE;
            wait_q <= 1'b1;
        end
        else
        begin
            busState_q <= busState_d;
            wait_q <= wait_d;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, clear and enable
    // ---------------------------------------------------------------
    logic [7:0] irqStatus_q;
    logic [7:0] irqStatus_d;
    logic [7:0] irqEnable_q;
    logic [7:0] irqEnable_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] irqClr;

    always_comb
    begin
        irqClr = 8'h00;
        irqEnable_d = irqEnable_q;
        if (accept & req.write & req.byteenable[0])
        begin
            if (hitClear)
                irqClr = req.writedata[7:0];
            if (hitEnable)
                irqEnable_d = req.writedata[7:0];
        end
        // New alarm in the clearing cycle wins
        irqStatus_d = newSet | (irqStatus_q & ~irqClr);
        irq_d = |(irqStatus_d & irqEnable_d);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irqStatus_q <= FLAGS_RESET;
            irqEnable_q <= IRQ_ENABLE_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            irqStatus_q <= irqStatus_d;
            irqEnable_q <= irqEnable_d;
            irq_q <= irq_d;
        end
    end

    // ---------------------------------------------------------------
    // Read capture and clear-on-read
    // ---------------------------------------------------------------
    // Answer is captured one edge ahead; the clear hits only the
    // bits that were returned, so an alarm arriving meanwhile survives.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rdLatch76_q;
    logic rdLatch76_d;
    logic rdLatch54_q;
    logic rdLatch54_d;
    logic [7:0] rdBits_q;
    logic [7:0] rdBits_d;

    always_comb
    begin
        rdata_d = rdata_q;
        rdLatch76_d = 1'b0;
        rdLatch54_d = 1'b0;
        rdBits_d = rdBits_q;
        if (capture & req.read)
        begin
            rdata_d = RDATA_RESET;
            rdBits_d = flags;
            if (hitLatch76)
            begin
                rdata_d[7:0] = byteCh7Ch6;
                rdLatch76_d = 1'b1;
            end
            else if (hitLatch54)
            begin
                rdata_d[7:0] = byteCh5Ch4;
                rdLatch54_d = 1'b1;
            end
            else if (hitTemp)
                rdata_d[7:0] = tempHeld;
            else if (hitStatus)
                rdata_d[7:0] = irqStatus_q;
            else if (hitEnable)
                rdata_d[7:0] = irqEnable_q;
            else
                rdata_d = RDATA_RESET;
        end
    end

    // Clear on the accepting edge, limited to returned bits
    always_comb
    begin
        clearMask = 8'h00;
        if (accept & req.read)
        begin
            if (rdLatch76_q)
                clearMask = rdBits_q & 8'hCC;
            else if (rdLatch54_q)
                clearMask = rdBits_q & 8'h33;
            else
                clearMask = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= RDATA_RESET;
            rdLatch76_q <= 1'b0;
            rdLatch54_q <= 1'b0;
            rdBits_q <= FLAGS_RESET;
        end
        else
        begin
            rdata_q <= rdata_d;
            rdLatch76_q <= rdLatch76_d;
            rdLatch54_q <= rdLatch54_d;
            rdBits_q <= rdBits_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign irq = irq_q;

endmodule

//--- rx_alarm_props.sv
// Purpose: Port-level checks of the alarm latch bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Flag checks only demand bits, never forbid extra set bits

`timescale 1ns/1ps

module rx_alarm_props
    import rx_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Comparators, sensor, interrupt
    input wire rx_alarm_t rxAlarm,
    input wire logic signed [7:0] tempInt,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    function automatic logic [7:0] pick(input rx_alarm_t a, input int u);
        return {a.high[u], a.low[u], 2'b00, a.high[u-1], a.low[u-1], 2'b00};
    endfunction

    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer after one wait cycle");
    property p_wait_back;
        !waitrequest || !(read || write) |=> waitrequest;
    endproperty
    a_wait_back: assert property (p_wait_back) else $error("waitrequest low without request");
    property p_upper;
        read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_reserved;
        read && !waitrequest && (address == LATCH_CH7_CH6_ADDR || address == LATCH_CH5_CH4_ADDR)
            |-> readdata[5:4] == 2'b00 && readdata[1:0] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved alarm bit set");
    // Condition two cycles back is already latched when the read is captured
    property p_set76;
        read && waitrequest && address == LATCH_CH7_CH6_ADDR && !$past(rst)
            |=> (readdata[7:0] & pick($past(rxAlarm, 2), 3)) == pick($past(rxAlarm, 2), 3);
    endproperty
    a_set76: assert property (p_set76) else $error("ch7/ch6 alarm lost");
    property p_set54;
        read && waitrequest && address == LATCH_CH5_CH4_ADDR && !$past(rst)
            |=> (readdata[7:0] & pick($past(rxAlarm, 2), 1)) == pick($past(rxAlarm, 2), 1);
    endproperty
    a_set54: assert property (p_set54) else $error("ch5/ch4 alarm lost");
    property p_zero_read;
        read && !waitrequest && (address == IRQ_CLEAR_ADDR || address == 10'h100) |-> readdata == 32'h0;
    endproperty
    a_zero_read: assert property (p_zero_read) else $error("write-only or unmapped read not zero");
    property p_irq_off;
        write && !waitrequest && address == IRQ_ENABLE_ADDR && byteenable[0] && writedata[7:0] == 8'h00
            |=> ##1 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq high with all sources disabled");
endmodule

bind rx_power_alarm_latch_bank rx_alarm_props u_props (.clock(clock), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxAlarm(rxAlarm), .tempInt(tempInt), .irq(irq));

//--- rx_power_alarm_latch_bank_bench.sv
// Purpose: Self-checking bench of the alarm latch bank
// Assumes: Avalon-MM master with one outstanding request
// Notes:   Random alarm patterns pulse for one cycle

`timescale 1ns/1ps

module rx_power_alarm_latch_bank_bench;
    import rx_alarm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0] byteenable = '0;
    logic [31:0] readdata;
    logic waitrequest;
    rx_alarm_t rxAlarm = '0;
    logic signed [7:0] tempInt = '0;
    logic irq;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] got;
    logic [7:0] pat;
    logic [7:0] en;
    logic [7:0] t;

    always #2.5 clock = ~clock;

    rx_power_alarm_latch_bank DUT (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .rxAlarm(rxAlarm), .tempInt(tempInt), .irq(irq));

    function automatic logic [7:0] expByte(input logic [7:0] p, input int u);
        rx_alarm_t a;
        a = rx_alarm_t'(p);
        return {a.high[u], a.low[u], 2'b00, a.high[u-1], a.low[u-1], 2'b00};
    endfunction

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic check_irq(input logic act, input logic exp);
        compares++;
        if (act !== exp)
        begin
            num_errors++;
            $display("Error at %0t: irq %b expected %b", $time, act, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Errors %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low
    task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        @(posedge clock);
        // Only the bench timeout ends a wait that never answers
        while (waitrequest !== 1'b0)
            @(posedge clock);
        got = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'hC164));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // Refused accesses
        bus(1'b0, IRQ_ENABLE_ADDR, 8'hFF, 4'hE);
        bus(1'b1, IRQ_ENABLE_ADDR, 8'h00, 4'hF);
        check(got, 32'h0);
        bus(1'b1, 10'h100, 8'h00, 4'hF);
        check(got, 32'h0);
        bus(1'b0, LATCH_CH7_CH6_ADDR, 8'hFF, 4'hF);
        bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
        check(got, 32'h0);
        for (int i = 0; i < 24; i++)
        begin
            pat = (i == 0) ? 8'hFF : 8'($urandom);
            en = 8'($urandom);
            bus(1'b0, IRQ_ENABLE_ADDR, en, 4'h1);
            rxAlarm <= rx_alarm_t'(pat);
            @(posedge clock);
            rxAlarm <= '0;
            bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
            check(got, {24'h0, expByte(pat, 3)});
            bus(1'b1, LATCH_CH5_CH4_ADDR, 8'h00, 4'hF);
            check(got, {24'h0, expByte(pat, 1)});
            bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
            check(got, 32'h0);
            bus(1'b1, LATCH_CH5_CH4_ADDR, 8'h00, 4'hF);
            check(got, 32'h0);
            bus(1'b1, IRQ_STATUS_ADDR, 8'h00, 4'hF);
            check(got, {24'h0, pat});
            check_irq(irq, |(pat & en));
            bus(1'b0, IRQ_CLEAR_ADDR, 8'hFF, 4'h1);
            repeat (2) @(posedge clock);
            check_irq(irq, 1'b0);
        end
        // Condition still present at the read keeps the flag set
        rxAlarm <= rx_alarm_t'(8'h08);
        repeat (2)
        begin
            bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
            check(got, 32'h80);
        end
        rxAlarm <= '0;
        bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
        check(got, 32'h80);
        bus(1'b1, LATCH_CH7_CH6_ADDR, 8'h00, 4'hF);
        check(got, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            t = (i == 0) ? 8'h9C : 8'($urandom);
            tempInt <= t;
            repeat (450) @(posedge clock);
            bus(1'b1, TEMP_MSB_ADDR, 8'h00, 4'hF);
            check(got, {24'h0, t});
        end
        bus(1'b0, IRQ_ENABLE_ADDR, 8'h00, 4'h1);
        give_verdict();
    end
endmodule
